// ### vir_map.svh
`ifndef VIR_MAP_SVH
`define VIR_MAP_SVH

// ----------------------------------------------------------------------------
// Input format select codes
// ----------------------------------------------------------------------------
`define VIR_FMT_422      2'h0
`define VIR_FMT_411      2'h1
`define VIR_FMT_211      2'h2
`define VIR_FMT_565      2'h3

// ----------------------------------------------------------------------------
// Chroma code select and reset values
// ----------------------------------------------------------------------------
`define VIR_CODE_TWOS    1'h0
`define VIR_CODE_OFFSET  1'h1
`define VIR_FMT_RESET    2'h0
`define VIR_CODE_RESET   1'h0

// ----------------------------------------------------------------------------
// Luma delay taps (group length minus one) and phases
// ----------------------------------------------------------------------------
`define VIR_TAP_PAIR     2'h1
`define VIR_TAP_QUAD     2'h3
`define VIR_PHASE_FIRST  2'h0
`define VIR_PHASE_THIRD  2'h2
`define VIR_PHASE_LAST   2'h3
`define VIR_BLANK_CODE   8'h00

// ----------------------------------------------------------------------------
// Matrix coefficients, scaled by 256, studio range out
// ----------------------------------------------------------------------------
`define VIR_K_RV         20'sh0015f
`define VIR_K_GV         20'sh000b3
`define VIR_K_GU         20'sh00056
`define VIR_K_BU         20'sh001bb
`define VIR_K_ROUND      20'sh00080
`define VIR_CLIP_LO      20'sh00000
`define VIR_CLIP_HI      20'sh000ff

`endif

// ### vir_pkg.sv
package vir_pkg;

  // --------------------------------------------------------------------------
  // Matrix state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
    logic       valid;
  } vir_mat_st_t;

  // --------------------------------------------------------------------------
  // Top state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [7:0]      lum_s1;
    logic [7:0]      chr_s1;
    logic            ref_s1;
    logic [7:0]      lum_s2;
    logic [7:0]      chr_s2;
    logic            ref_s2;
    logic            ref_prev;
    logic [1:0]      fmt;
    logic            code;
    logic [1:0]      phase;
    logic [7:0]      u_acc;
    logic [7:0]      v_acc;
    logic [7:0]      u_lat;
    logic [7:0]      v_lat;
    logic [3:0][7:0] ydly;
    logic [3:0]      vdly;
    logic [7:0]      byp_r;
    logic [7:0]      byp_g;
    logic [7:0]      byp_b;
    logic            byp_v;
    logic [7:0]      out_r;
    logic [7:0]      out_g;
    logic [7:0]      out_b;
    logic            out_v;
  } vir_top_st_t;

endpackage

// ### vir_matrix.sv
`timescale 1ns/1ps
`include "vir_map.svh"

module vir_matrix
  import vir_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // Sample in, chroma already twos complement
  input  wire logic [7:0] y_i,
  input  wire logic [7:0] u_i,
  input  wire logic [7:0] v_i,
  input  wire logic       valid_i,
  // Codes out, one cycle later
  output logic      [7:0] r_o,
  output logic      [7:0] g_o,
  output logic      [7:0] b_o,
  output logic            valid_o
);

  // --------------------------------------------------------------------------
  // Rounding clamp to one code
  // --------------------------------------------------------------------------
  function automatic logic [7:0] clip8(input logic signed [19:0] x);
    logic signed [19:0] s;
    s = x >>> 8;
    if (s < `VIR_CLIP_LO) begin
      clip8 = 8'h00;
    end else if (s > `VIR_CLIP_HI) begin
      clip8 = 8'hff;
    end else begin
      clip8 = s[7:0];
    end
  endfunction

  vir_mat_st_t        q;
  vir_mat_st_t        d;
  logic signed [19:0] y_term;
  logic signed [19:0] u_ext;
  logic signed [19:0] v_ext;
  logic signed [19:0] r_sum;
  logic signed [19:0] g_sum;
  logic signed [19:0] b_sum;

  // --------------------------------------------------------------------------
  // Colour space conversion
  // --------------------------------------------------------------------------
  // Unity luma gain keeps black at 16 and white at 235 on the DACs
  always_comb begin
    d      = q;
    y_term = $signed({4'h0, y_i, 8'h00});
    u_ext  = $signed({{12{u_i[7]}}, u_i});
    v_ext  = $signed({{12{v_i[7]}}, v_i});
    r_sum  = y_term + v_ext * `VIR_K_RV + `VIR_K_ROUND;
    g_sum  = y_term - v_ext * `VIR_K_GV - u_ext * `VIR_K_GU + `VIR_K_ROUND;
    b_sum  = y_term + u_ext * `VIR_K_BU + `VIR_K_ROUND;
    d.r     = clip8(r_sum);
    d.g     = clip8(g_sum);
    d.b     = clip8(b_sum);
    d.valid = valid_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign r_o     = q.r;
  assign g_o     = q.g;
  assign b_o     = q.b;
  assign valid_o = q.valid;

  AST_MAT_GREY: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (u_i == 8'h00 && v_i == 8'h00) |=> (r_o == $past(y_i) && g_o == $past(y_i) && b_o == $past(y_i)))
    else $error("grey input did not map to equal codes");

  AST_MAT_LATENCY: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    valid_i |=> valid_o)
    else $error("matrix valid not one cycle after input");

endmodule

// ### vir_top.sv
// Contract
// - Demultiplex 4:1:1, 4:2:2, 2:1:1 streams into one full sample per pixel.
// - 4:2:2: Y every clock, chroma alternates U then V, pair shared by two.
// - 4:1:1: chroma bits 7..4 carry U and V pairs, MSB first, over four clocks.
// - 2:1:1: luma bus carries U, Y, V, Y; chroma bus unused.
// - RGB 5:6:5: chroma bit7 G0, bits 6..2 red, bit1 G5.
// - RGB 5:6:5 bypasses the matrix straight to the three codes.
// - Chroma code select 0 means twos complement, 1 means binary offset.
// - A two-bit input format select chooses the input format.
// - Format codes: 00 4:2:2, 01 4:1:1, 10 2:1:1, 11 RGB 5:6:5.
// - Rising edge of line active reference starts active video, first byte aligned.
// - While line active reference is low, outputs are blanked.
// - Matrix converts YUV to RGB with BT.601 coefficients within about 1.5 LSB.
// - Three independent 8-bit codes, one pixel per clock (one per two clocks in 2:1:1), up to 66 MHz.
// - All control bits clear to zero on control reset.
`timescale 1ns/1ps
`include "vir_map.svh"

module vir_top
  import vir_pkg::*;
(
  // Clock and control reset
  input  wire logic       CLOCK_I,
  input  wire logic       RST_N_I,
  // Video pins
  input  wire logic [7:0] LUMA_PRIMARY_BUS_I,
  input  wire logic [7:0] CHROMA_AUX_BUS_I,
  input  wire logic       LINE_ACTIVE_REF_I,
  // Control bits from the control interface
  input  wire logic [1:0] INPUT_FORMAT_SELECT_I,
  input  wire logic       CHROMA_CODE_SELECT_I,
  // DAC codes
  output logic      [7:0] R_CODE_O,
  output logic      [7:0] G_CODE_O,
  output logic      [7:0] B_CODE_O,
  output logic            PIX_VALID_O
);

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [7:0] chroma_twos(input logic [7:0] c, input logic offset);
    if (offset == `VIR_CODE_OFFSET) begin
      chroma_twos = {~c[7], c[6:0]};
    end else begin
      chroma_twos = c;
    end
  endfunction

  function automatic logic [7:0] widen5(input logic [4:0] x);
    widen5 = {x, x[4:2]};
  endfunction

  function automatic logic [7:0] widen6(input logic [5:0] x);
    widen6 = {x, x[5:4]};
  endfunction

  vir_top_st_t q;
  vir_top_st_t d;
  logic        line_rise;
  logic [1:0]  phase_eff;
  logic        group_last;
  logic        y_strobe;
  logic [1:0]  tap;
  logic [7:0]  mat_y;
  logic [7:0]  mat_u;
  logic [7:0]  mat_v;
  logic        mat_in_v;
  logic [7:0]  mat_r;
  logic [7:0]  mat_g;
  logic [7:0]  mat_b;
  logic        mat_v_out;
  logic [4:0]  red5;
  logic [5:0]  grn6;
  logic [4:0]  blu5;

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb begin
    d = q;

    // Pins pass two flops before anything reads them
    d.lum_s1   = LUMA_PRIMARY_BUS_I;
    d.chr_s1   = CHROMA_AUX_BUS_I;
    d.ref_s1   = LINE_ACTIVE_REF_I;
    d.lum_s2   = q.lum_s1;
    d.chr_s2   = q.chr_s1;
    d.ref_s2   = q.ref_s1;
    d.ref_prev = q.ref_s2;

    // Control bits, cleared by reset below
    d.fmt  = INPUT_FORMAT_SELECT_I;
    d.code = CHROMA_CODE_SELECT_I;

    // Byte phase within the chroma group
    line_rise = q.ref_s2 & ~q.ref_prev;
    phase_eff = line_rise ? `VIR_PHASE_FIRST : q.phase;
    d.phase   = phase_eff + 2'h1;
    if (q.fmt == `VIR_FMT_422) begin
      group_last = phase_eff[0];
    end else begin
      group_last = (phase_eff == `VIR_PHASE_LAST);
    end

    // Chroma gathering per format
    if (q.ref_s2) begin
      unique case (q.fmt)
        `VIR_FMT_422: begin
          if (!phase_eff[0]) begin
            d.u_acc = q.chr_s2;
          end else begin
            d.u_lat = q.u_acc;
            d.v_lat = q.chr_s2;
          end
        end
        `VIR_FMT_411: begin
          d.u_acc = {q.u_acc[5:0], q.chr_s2[7:6]};
          d.v_acc = {q.v_acc[5:0], q.chr_s2[5:4]};
          if (group_last) begin
            d.u_lat = {q.u_acc[5:0], q.chr_s2[7:6]};
            d.v_lat = {q.v_acc[5:0], q.chr_s2[5:4]};
          end
        end
        `VIR_FMT_211: begin
          if (phase_eff == `VIR_PHASE_FIRST) begin
            d.u_acc = q.lum_s2;
          end
          if (phase_eff == `VIR_PHASE_THIRD) begin
            d.v_acc = q.lum_s2;
          end
          if (group_last) begin
            d.u_lat = q.u_acc;
            d.v_lat = q.v_acc;
          end
        end
        `VIR_FMT_565: begin
        end
      endcase
    end

    // Luma waits one whole group so its chroma is complete
    y_strobe = q.ref_s2 & ((q.fmt != `VIR_FMT_211) | phase_eff[0]);
    d.ydly   = {q.ydly[2:0], q.lum_s2};
    d.vdly   = {q.vdly[2:0], y_strobe};

    // Bypass stage, same depth as the matrix
    d.byp_r = widen5(red5);
    d.byp_g = widen6(grn6);
    d.byp_b = widen5(blu5);
    d.byp_v = q.ref_s2 & (q.fmt == `VIR_FMT_565);

    // Output select and blanking
    if (q.fmt == `VIR_FMT_565) begin
      d.out_v = q.byp_v;
      d.out_r = q.byp_r;
      d.out_g = q.byp_g;
      d.out_b = q.byp_b;
    end else begin
      d.out_v = mat_v_out;
      d.out_r = mat_r;
      d.out_g = mat_g;
      d.out_b = mat_b;
    end
    if (!d.out_v) begin
      d.out_r = `VIR_BLANK_CODE;
      d.out_g = `VIR_BLANK_CODE;
      d.out_b = `VIR_BLANK_CODE;
    end
  end

  // --------------------------------------------------------------------------
  // Datapath taps
  // --------------------------------------------------------------------------
  // Missing green and blue positions taken from the luma bus
  assign red5     = q.chr_s2[6:2];
  assign grn6     = {q.chr_s2[1], q.chr_s2[0], q.lum_s2[7:5], q.chr_s2[7]};
  assign blu5     = q.lum_s2[4:0];
  assign tap      = (q.fmt == `VIR_FMT_422) ? `VIR_TAP_PAIR : `VIR_TAP_QUAD;
  assign mat_y    = q.ydly[tap];
  assign mat_u    = chroma_twos(q.u_lat, q.code);
  assign mat_v    = chroma_twos(q.v_lat, q.code);
  assign mat_in_v = q.vdly[tap] & (q.fmt != `VIR_FMT_565);

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------------
  // Matrix
  // --------------------------------------------------------------------------
  // A pixel per clock; the multipliers sit in one stage, so the clock limit is theirs
  vir_matrix u_matrix (
    .clk_i   (CLOCK_I),
    .rst_n_i (RST_N_I),
    .y_i     (mat_y),
    .u_i     (mat_u),
    .v_i     (mat_v),
    .valid_i (mat_in_v),
    .r_o     (mat_r),
    .g_o     (mat_g),
    .b_o     (mat_b),
    .valid_o (mat_v_out)
  );

  assign R_CODE_O    = q.out_r;
  assign G_CODE_O    = q.out_g;
  assign B_CODE_O    = q.out_b;
  assign PIX_VALID_O = q.out_v;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  AST_BLANK_LOW: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    !PIX_VALID_O |-> (R_CODE_O == 8'h00 && G_CODE_O == 8'h00 && B_CODE_O == 8'h00))
    else $error("codes not blanked while no pixel");

  AST_CTRL_RESET: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    $rose(RST_N_I) |-> (q.fmt == 2'h0 && q.code == 1'h0))
    else $error("control bits not cleared by reset");

  AST_PHASE_RESTART: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (q.ref_s2 && !q.ref_prev) |=> (q.phase == 2'h1))
    else $error("phase did not restart on line start");

  AST_LINE_START: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    ($rose(q.ref_s2) && q.fmt == 2'h3) ##1 (q.fmt == 2'h3) |-> ##1 PIX_VALID_O)
    else $error("bypass pixel not out two cycles after line start");

  AST_BYPASS_RED: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (q.ref_s2 && q.fmt == 2'h3) ##2 (q.fmt == 2'h3)
      |-> (R_CODE_O == {$past(q.chr_s2[6:2], 2), $past(q.chr_s2[6:4], 2)}))
    else $error("bypass red code wrong");

  AST_BYPASS_GREEN: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (q.ref_s2 && q.fmt == 2'h3) ##2 (q.fmt == 2'h3)
      |-> (G_CODE_O[7] == $past(q.chr_s2[1], 2) && G_CODE_O[2] == $past(q.chr_s2[7], 2)))
    else $error("bypass green bits misplaced");

  AST_PAIR_CHROMA: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (q.fmt == 2'h0 && q.ref_s2 && phase_eff[0])
      |=> (q.v_lat == $past(q.chr_s2) && q.u_lat == $past(q.chr_s2, 2)))
    else $error("pair chroma latch wrong");

  AST_QUAD_CHROMA: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (q.fmt == 2'h1 && q.ref_s2 && phase_eff == 2'h3)
      |=> (q.u_lat == {$past(q.chr_s2[7:6], 4), $past(q.chr_s2[7:6], 3),
                       $past(q.chr_s2[7:6], 2), $past(q.chr_s2[7:6], 1)}))
    else $error("quad chroma U assembly wrong");

  AST_MUXED_CHROMA: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (q.fmt == 2'h2 && q.ref_s2 && phase_eff == 2'h3)
      |=> (q.u_lat == $past(q.lum_s2, 4) && q.v_lat == $past(q.lum_s2, 2)))
    else $error("muxed chroma latch wrong");

  AST_MUXED_RATE: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (q.fmt == 2'h2 && PIX_VALID_O && q.ref_s2) |=> !PIX_VALID_O)
    else $error("muxed format gave two pixels in a row");

  AST_PAIR_RATE: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (q.fmt == 2'h0 && q.ref_s2) [*5] |-> PIX_VALID_O)
    else $error("pair format not one pixel per clock");

  AST_OFFSET_CODE: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (q.code == 1'h1 && q.u_lat == 8'h80 && q.v_lat == 8'h80) |-> (mat_u == 8'h00 && mat_v == 8'h00))
    else $error("binary offset chroma not recentred");

  AST_QUAD_VCHROMA: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (q.fmt == 2'h1 && q.ref_s2 && phase_eff == 2'h3)
      |=> (q.v_lat == {$past(q.chr_s2[5:4], 4), $past(q.chr_s2[5:4], 3),
                       $past(q.chr_s2[5:4], 2), $past(q.chr_s2[5:4], 1)}))
    else $error("quad chroma V assembly wrong");

  AST_BYPASS_BLUE: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (q.ref_s2 && q.fmt == 2'h3) ##2 (q.fmt == 2'h3)
      |-> (B_CODE_O == {$past(q.lum_s2[4:0], 2), $past(q.lum_s2[4:2], 2)}))
    else $error("bypass blue code wrong");

  // Eight quiet cycles outlast the deepest pipe, so nothing may still be coming
  AST_BLANK_IDLE: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (!q.ref_s2) [*8] |-> !PIX_VALID_O)
    else $error("pixel out long after line ended");

  AST_MUXED_GAP: assert property (
    @(posedge CLOCK_I) disable iff (!RST_N_I)
    (q.fmt == 2'h2 && q.ref_s2 && !phase_eff[0]) |=> !q.vdly[0])
    else $error("muxed chroma byte taken as a pixel");

endmodule

// ### vir_src_model.sv
`timescale 1ns/1ps

module vir_src_model (
  // Clock
  input  wire logic       clk_i,
  // Video pins
  output logic      [7:0] luma_o,
  output logic      [7:0] chroma_o,
  output logic            ref_o,
  // Nothing queued
  output logic            idle_o
);
  // ----------------------------------------------------------------
  // Words and line lengths, filled by the bench
  // ----------------------------------------------------------------
  logic [15:0] wq[$];
  int          lq[$];
  int          rem = 0;
  bit          gap = 1'b0;
  logic [15:0] w;

  initial begin
    luma_o   = 8'h00;
    chroma_o = 8'h00;
    ref_o    = 1'b0;
    idle_o   = 1'b1;
  end

  // ----------------------------------------------------------------
  // Driver
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rem == 0 && !gap && lq.size() != 0) begin
      rem = lq.pop_front();
    end
    if (rem != 0) begin
      w = wq.pop_front();
      luma_o   <= w[15:8];
      chroma_o <= w[7:0];
      ref_o    <= 1'b1;
      rem--;
      gap = (rem == 0);
    end else begin
      // Released bus keeps moving so stale bytes cannot pass
      luma_o   <= ~luma_o;
      chroma_o <= chroma_o + 8'h3b;
      ref_o    <= 1'b0;
      gap = 1'b0;
    end
    idle_o <= (rem == 0) && (lq.size() == 0);
  end
endmodule

// ### video_input_reformatter_matrix_tb_top.sv
`timescale 1ns/1ps

module video_input_reformatter_matrix_tb_top;
  // ----------------------------------------------------------------
  // Signals and model state
  // ----------------------------------------------------------------
  typedef struct {int d; int r; int g; int b; int t;} vir_exp_t;

  logic       clk        = 1'b0;
  logic       rst_n      = 1'b0;
  logic [1:0] fmt        = 2'h0;
  logic       code       = 1'b0;
  wire  [7:0] luma_w;
  wire  [7:0] chroma_w;
  wire  [7:0] r_w;
  wire  [7:0] g_w;
  wire  [7:0] b_w;
  wire        ref_w;
  wire        val_w;
  wire        idle_w;
  int         num_errors = 0;
  int         checked    = 0;
  int         cyc        = 0;
  int         ph         = 0;
  int         yq[$];
  vir_exp_t   eq[$];
  vir_exp_t   e;
  logic [7:0] u          = 8'h00;
  logic [7:0] v          = 8'h00;
  logic [5:0] g6;

  always #10 clk = ~clk;

  vir_src_model src (
    .clk_i    (clk),
    .luma_o   (luma_w),
    .chroma_o (chroma_w),
    .ref_o    (ref_w),
    .idle_o   (idle_w)
  );

  vir_top dut (
    .CLOCK_I               (clk),
    .RST_N_I               (rst_n),
    .LUMA_PRIMARY_BUS_I    (luma_w),
    .CHROMA_AUX_BUS_I      (chroma_w),
    .LINE_ACTIVE_REF_I     (ref_w),
    .INPUT_FORMAT_SELECT_I (fmt),
    .CHROMA_CODE_SELECT_I  (code),
    .R_CODE_O              (r_w),
    .G_CODE_O              (g_w),
    .B_CODE_O              (b_w),
    .PIX_VALID_O           (val_w)
  );

  // ----------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------
  function automatic int clip(int x);
    return (x < 0) ? 0 : ((x > 255) ? 255 : x);
  endfunction

  function automatic int sgn(int x);
    return code ? x - 128 : ((x > 127) ? x - 256 : x);
  endfunction

  // Tolerance of one code, the matrix only has to be close
  task automatic flush(int lat);
    int y;
    int k;
    int uu;
    int vv;
    uu = sgn(u);
    vv = sgn(v);
    // Latency counts from the edge that drove the pin, one before this sample
    while (yq.size() != 0) begin
      k = yq.pop_front();
      y = (k % 256) * 256 + 128;
      eq.push_back('{k / 256 - 1 + lat, clip((y + 351 * vv) >>> 8), clip((y - 179 * vv - 86 * uu) >>> 8),
                     clip((y + 443 * uu) >>> 8), 1});
    end
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      num_errors++;
      test_done();
    end
    if (!rst_n) begin
      yq.delete();
      eq.delete();
      ph = 0;
    end else if (ref_w !== 1'b1) begin
      ph = 0;
    end else begin
      case (fmt)
        2'h0: begin
          yq.push_back(cyc * 256 + luma_w);
          if (ph[0]) begin
            v = chroma_w;
            flush(6);
          end else begin
            u = chroma_w;
          end
        end
        2'h1: begin
          yq.push_back(cyc * 256 + luma_w);
          u = {u[5:0], chroma_w[7:6]};
          v = {v[5:0], chroma_w[5:4]};
          if (ph == 3) flush(8);
        end
        2'h2: begin
          if (ph == 0) u = luma_w;
          else if (ph == 2) v = luma_w;
          else yq.push_back(cyc * 256 + luma_w);
          if (ph == 3) flush(8);
        end
        default: begin
          g6 = {chroma_w[1:0], luma_w[7:5], chroma_w[7]};
          eq.push_back('{cyc - 1 + 4, {chroma_w[6:2], chroma_w[6:4]}, {g6, g6[5:4]},
                         {luma_w[4:0], luma_w[4:2]}, 0});
        end
      endcase
      ph = (ph + 1) % 4;
    end
  end

  // ----------------------------------------------------------------
  // Comparison, once per cycle at the settled edge
  // ----------------------------------------------------------------
  task automatic chk_code(logic [7:0] act, int ex, int tol);
    checked++;
    if ((^act === 1'bx) || (act > ex + tol) || (act + tol < ex)) begin
      num_errors++;
      $display("CHECK FAILED %0t code %0h expected %0h", $time, act, ex);
    end
  endtask

  task automatic chk_valid(logic act, logic ex);
    checked++;
    if (act !== ex) begin
      num_errors++;
      $display("CHECK FAILED %0t pixel valid %b expected %b", $time, act, ex);
    end
  endtask

  always @(negedge clk) begin
    if (eq.size() != 0 && eq[0].d == cyc) begin
      e = eq.pop_front();
      chk_valid(val_w, 1'b1);
      chk_code(r_w, e.r, e.t);
      chk_code(g_w, e.g, e.t);
      chk_code(b_w, e.b, e.t);
    end else begin
      chk_valid(val_w, 1'b0);
      chk_code(r_w, 0, 0);
      chk_code(g_w, 0, 0);
      chk_code(b_w, 0, 0);
    end
  end

  task automatic test_done();
    if (num_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus: every format and code, then random ones
  // ----------------------------------------------------------------
  initial begin
    int n;
    n = $urandom(32'h953e0a72);
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 14; i++) begin
      fmt  <= (i < 8) ? i[1:0] : 2'($urandom);
      code <= (i < 8) ? i[2] : 1'($urandom);
      repeat (3) @(posedge clk);
      // Two lines back to back, one low cycle between them
      for (int k = 0; k < 2; k++) begin
        n = (fmt == 2'h0) ? 2 : ((fmt == 2'h3) ? 1 : 4);
        n = n * (1 + $urandom % 5);
        repeat (n) src.wq.push_back(16'($urandom));
        src.lq.push_back(n);
      end
      repeat (2) @(posedge clk);
      while (!idle_w) @(posedge clk);
      repeat (12) @(posedge clk);
      if (i == 9) begin
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
      end
    end
    if (eq.size() != 0) begin
      num_errors++;
      $display("CHECK FAILED %0t pixels still expected at end", $time);
    end
    test_done();
  end
endmodule
